// [rtl/conv_map.svh]
// Behaviour
// - host starts conversion with active-low start pulse
// - start may come from external sample timer
// - host waits 6.5 us before reading result; with use_busy high the host reads at busy rise instead
// - busy low during conversion, rises at end
// - wide variant 16-bit bus, byte variant 8-bit
// - byte variant reads result as two halves
// - strobes held low: data valid at busy rise
// - standalone needs periodic start, latch on busy rise
// - isolate converter bus from processor during conversion
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH
// clock period in picoseconds
`define CLK_PERIOD_PS 8000
// nominal conversion time in nanoseconds, a plain default
`define CONV_TIME_NS 5000
`define CONV_CYCLES ((`CONV_TIME_NS * 1000) / `CLK_PERIOD_PS)
// least host wait before reading, in nanoseconds
`define READ_WAIT_NS 6500
`define READ_WAIT_CYCLES ((`READ_WAIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// length of the start pulse in cycles
`define START_PULSE_CYCLES 4
// cycles a read strobe is held low
`define READ_STROBE_CYCLES 2
// strobe-high gap between the two byte reads, in cycles
`define READ_GAP_CYCLES 1
// counter width
`define CNT_W 11
// data widths
`define WORD_W 16
`define BYTE_W 8
`endif

// [rtl/conv_pkg.sv]
package conv_pkg;
  // device conversion sequencing
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b01,
    DEV_CONV = 2'b10
  } dev_state_t;
  // host sequencing
  typedef enum logic [5:0] {
    H_IDLE  = 6'b000001,
    H_START = 6'b000010,
    H_WAIT  = 6'b000100,
    H_READ  = 6'b001000,
    H_READ2 = 6'b010000,
    H_PUSH  = 6'b100000
  } host_state_t;
endpackage

// [rtl/conv_if.sv]
`include "conv_map.svh"
interface conv_if;
  logic conversion_start_n; // start pulse, active low
  logic busy_n;             // low while converting
  logic cs_n;               // chip select, active low
  logic rd_n;               // read strobe, active low
  logic byte_mode;          // high selects 8-bit variant
  logic hi_byte;            // byte variant: high half requested
  logic [`WORD_W-1:0] data_out; // device data
  logic [`WORD_W-1:0] data_oe;  // device output enables
  logic [`WORD_W-1:0] data_bus; // resolved level seen by host
  // unresolved lanes float high in this model
  assign data_bus = data_out | ~data_oe;
  modport dev (input conversion_start_n, cs_n, rd_n, byte_mode, hi_byte,
    output busy_n, data_out, data_oe);
  modport host (output conversion_start_n, cs_n, rd_n, hi_byte,
    input busy_n, data_bus, byte_mode);
endinterface

// [rtl/word_buffer.sv]
`include "conv_map.svh"
module word_buffer (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [`WORD_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [`WORD_W-1:0] out_data
);
  logic [`WORD_W-1:0] mem [2]; // two-entry storage
  logic wr_ptr; // write index
  logic rd_ptr; // read index
  logic [1:0] count; // entries held
  logic push;
  logic pop;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // word_buffer

// [rtl/conv_device.sv]
`include "conv_map.svh"
module conv_device
  import conv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  conv_if.dev link,
  input wire logic [`WORD_W-1:0] sample, // value to convert
  output logic conv_done // pulse at end of conversion
);
  dev_state_t state; // conversion state
  logic [`CNT_W-1:0] cnt; // conversion timer
  logic start_d; // previous start level
  logic [`WORD_W-1:0] held; // sampled input
  logic [`WORD_W-1:0] result; // output latch
  logic drive; // bus enable
  // falling start edge begins conversion, end of count finishes it
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= DEV_IDLE;
      cnt <= '0;
      start_d <= 1'b1;
      held <= '0;
    end else begin
      start_d <= link.conversion_start_n;
      unique case (state)
        DEV_IDLE: begin
          if (start_d && !link.conversion_start_n) begin
            held <= sample;
            cnt <= `CNT_W'(`CONV_CYCLES - 1);
            state <= DEV_CONV;
          end
        end
        DEV_CONV: begin
          if (cnt == '0) state <= DEV_IDLE;
          else cnt <= cnt - 1'b1;
        end
      endcase
    end
  end
  // result latched as conversion ends, valid by busy rise
  always_ff @(posedge clk) begin
    if (rst) result <= '0;
    else if (state == DEV_CONV && cnt == '0) result <= held;
  end
  assign conv_done = (state == DEV_CONV) && (cnt == '0);
  assign link.busy_n = (state != DEV_CONV);
  assign drive = !link.cs_n && !link.rd_n;
  // byte variant places chosen half on low lanes
  always_comb begin
    if (link.byte_mode) begin
      link.data_out = {8'h00, link.hi_byte ? result[15:8] : result[7:0]};
      link.data_oe = drive ? 16'h00FF : 16'h0000;
    end else begin
      link.data_out = result;
      link.data_oe = drive ? 16'hFFFF : 16'h0000;
    end
  end
endmodule // conv_device

// [rtl/conv_host.sv]
`include "conv_map.svh"
module conv_host
  import conv_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  conv_if.host link,
  input wire logic start_req, // pulse: run one conversion
  input wire logic use_busy, // 1: wait on busy rise, 0: fixed wait
  output logic req_ready, // high when a start is accepted
  output logic word_valid,
  input wire logic word_ready, // receiver may stall
  output logic [`WORD_W-1:0] word
);
  // sequence position now and for the next cycle
  host_state_t state; // host sequence position
  host_state_t next_state; // position after this edge
  // timing
  logic [`CNT_W-1:0] cnt; // pulse, wait, gap and strobe timer
  logic cnt_zero; // timer has run out
  // completion detection
  logic busy_d; // busy level one cycle back
  logic busy_rise; // busy returned high
  // bus side
  logic strobe; // chip select and read asserted
  logic [`WORD_W-1:0] acc; // assembled result
  // stream side
  logic buf_push; // word offered to the buffer
  logic buf_ready; // buffer has a free entry

  // timer load value for a span of n cycles
  // the timer counts down to zero, so n cycles load n - 1
  // a span of zero cycles is never asked for
  // callers pass counts that fit the timer width
  function automatic logic [`CNT_W-1:0] span(input int unsigned n);
    return `CNT_W'(n - 1);
  endfunction

  // timer run out, shared by every timed state
  assign cnt_zero = (cnt == '0);

  // busy edge: low one cycle back, high now
  // the edge register resets high, the idle level of busy,
  // so no false completion follows reset
  assign busy_rise = !busy_d && link.busy_n;

  // strobes low for a whole first read
  // and for the last cycles of the second read;
  // the first cycle of the second read is a gap with strobes high,
  // so the byte variant sees two separate accesses
  assign strobe = (state == H_READ)
    || (state == H_READ2 && cnt < `CNT_W'(`READ_STROBE_CYCLES));

  // a start is accepted only while idle
  assign req_ready = (state == H_IDLE);

  // start pulse stands for the whole start state
  assign link.conversion_start_n = (state != H_START);

  // strobes stay high outside reads, so the converter bus
  // is left alone while a conversion runs
  assign link.cs_n = !strobe;
  assign link.rd_n = !strobe;

  // high half requested during the second read only
  assign link.hi_byte = (state == H_READ2);

  // word handed over while the push state stands
  assign buf_push = (state == H_PUSH);

  // next sequence position
  always_comb begin
    // stay put unless a branch below moves on
    next_state = state;
    unique case (state)
      // wait for a request from the host side
      H_IDLE: begin
        if (start_req) begin
          next_state = H_START;
        end
      end
      // start pulse held for its full width
      H_START: begin
        if (cnt_zero) begin
          next_state = H_WAIT;
        end
      end
      // busy rise, when used, or the full fixed wait
      H_WAIT: begin
        if ((use_busy && busy_rise) || cnt_zero) begin
          next_state = H_READ;
        end
      end
      // whole word, or low half on the byte variant
      H_READ: begin
        if (cnt_zero) begin
          if (link.byte_mode) begin
            // second access fetches the high half
            next_state = H_READ2;
          end else begin
            // one access carries the whole result
            next_state = H_PUSH;
          end
        end
      end
      // gap, then high half on the byte variant
      H_READ2: begin
        if (cnt_zero) begin
          next_state = H_PUSH;
        end
      end
      // hold the word until the buffer takes it
      H_PUSH: begin
        if (buf_ready) begin
          next_state = H_IDLE;
        end
      end
    endcase
  end

  // sequence register
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle, strobes and start high
      state <= H_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // timer: loaded as each timed state is entered, then counts down
  // and rests at zero until the next load
  // a change of position always reloads
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (next_state != state) begin
      unique case (next_state)
        // nothing timed while idle or pushing
        H_IDLE, H_PUSH: begin
          cnt <= '0;
        end
        // start pulse width
        H_START: begin
          cnt <= span(`START_PULSE_CYCLES);
        end
        // least wait before the first read
        H_WAIT: begin
          cnt <= span(`READ_WAIT_CYCLES);
        end
        // first read strobe
        H_READ: begin
          cnt <= span(`READ_STROBE_CYCLES);
        end
        // gap plus second read strobe
        H_READ2: begin
          cnt <= span(`READ_GAP_CYCLES + `READ_STROBE_CYCLES);
        end
      endcase
    end else if (!cnt_zero) begin
      // count down inside a timed state
      cnt <= cnt - 1'b1;
    end
  end

  // busy edge register
  always_ff @(posedge clk) begin
    if (rst) begin
      // idle level of busy
      busy_d <= 1'b1;
    end else begin
      busy_d <= link.busy_n;
    end
  end

  // result assembly: data taken in the last strobe cycle,
  // when the bus has stood driven for the whole strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= '0;
    end else if (state == H_READ && cnt_zero) begin
      if (link.byte_mode) begin
        // low half arrives first on the low lanes
        acc[`BYTE_W-1:0] <= link.data_bus[`BYTE_W-1:0];
      end else begin
        // full width in one access
        acc <= link.data_bus;
      end
    end else if (state == H_READ2 && cnt_zero) begin
      // high half, also on the low lanes
      acc[`WORD_W-1:`BYTE_W] <= link.data_bus[`BYTE_W-1:0];
    end
  end

  // two-entry buffer: once both entries are full, a stalled receiver holds the host in the push
  // state, so no word is lost and no new start is accepted meanwhile
  word_buffer i_word_buffer (
    .clk(clk),
    .rst(rst),
    .in_valid(buf_push),
    .in_ready(buf_ready),
    .in_data(acc),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word)
  );
endmodule // conv_host

// [tb/conv_properties.sv]
`include "conv_map.svh"
module conv_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic conversion_start_n,
  input wire logic busy_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_mode,
  input wire logic hi_byte,
  input wire logic [`WORD_W-1:0] data_oe,
  input wire logic [`WORD_W-1:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain for all checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  start_len_a: assert property (
    $fell(conversion_start_n) |-> !conversion_start_n[*4] ##1 conversion_start_n)
    else $error("start pulse width wrong");
  busy_start_a: assert property (
    $fell(conversion_start_n) |-> ##[1:2] !busy_n)
    else $error("busy did not fall after start");
  no_early_read_a: assert property (
    !busy_n |-> cs_n && rd_n)
    else $error("read during conversion");
  oe_gate_a: assert property (
    (cs_n || rd_n) |-> data_oe == '0)
    else $error("data driven without strobes");
  result_hold_a: assert property (
    busy_n && $past(busy_n) && !byte_mode && $stable(byte_mode) |-> $stable(data_out))
    else $error("result changed while idle");
  wide_read_a: assert property (
    !cs_n && !rd_n && !byte_mode |-> ##[0:1] &data_oe)
    else $error("wide read lanes not driven");
  byte_lanes_a: assert property (
    byte_mode |-> data_oe[15:8] == '0)
    else $error("upper lanes driven in byte mode");
  strobe_len_a: assert property (
    $fell(rd_n) |-> !cs_n ##1 (!rd_n && !cs_n) ##1 (rd_n && cs_n))
    else $error("read strobe shape wrong");
  two_reads_a: assert property (
    $fell(rd_n) && byte_mode && !hi_byte |-> ##[2:100] ($fell(rd_n) && hi_byte))
    else $error("high half not read");
  // main scenarios
  cover property ($rose(busy_n));
  cover property ($fell(rd_n) && hi_byte);
  cover property ($fell(rd_n) && !byte_mode);
  cover property ($rose(rd_n) && hi_byte);
endmodule // conv_properties

// [tb/adc_conversion_host_interface_bench.sv]
`include "conv_map.svh"
module adc_conversion_host_interface_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, start_req, use_busy, word_ready, req_ready, word_valid, conv_done;
  logic [`WORD_W-1:0] sample, word;
  logic [15:0] pat [4] = '{16'h8001, 16'hA5C3, 16'h12EF, 16'h7E00};
  int errors, num_checks;
  int n_done; // conversions the device finished
  conv_if lk();
  conv_device i_conv_device (.clk(clk), .rst(rst), .link(lk.dev), .sample(sample),
    .conv_done(conv_done));
  conv_host i_conv_host (.clk(clk), .rst(rst), .link(lk.host), .start_req(start_req),
    .use_busy(use_busy), .req_ready(req_ready), .word_valid(word_valid),
    .word_ready(word_ready), .word(word));
  conv_properties chk (.clk(clk), .rst(rst), .conversion_start_n(lk.conversion_start_n),
    .busy_n(lk.busy_n), .cs_n(lk.cs_n), .rd_n(lk.rd_n), .byte_mode(lk.byte_mode),
    .hi_byte(lk.hi_byte), .data_oe(lk.data_oe), .data_out(lk.data_out));
  // count finished conversions
  always @(posedge clk) begin
    if (rst) begin
      n_done <= 0;
    end else if (conv_done === 1'b1) begin
      n_done <= n_done + 1;
    end
  end
  // compare and count
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  // request one conversion once the host is idle
  task automatic start(logic [15:0] s);
    int n = 0;
    while (req_ready !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    check("host ready", 16'h0001, {15'h0000, req_ready});
    sample = s;
    start_req = 1'b1;
    @(posedge clk);
    #1 start_req = 1'b0;
  endtask
  // accept one word from the stream
  task automatic take(logic [15:0] exp);
    int n = 0;
    word_ready = 1'b1;
    while (word_valid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    check("word valid", 16'h0001, {15'h0000, word_valid});
    check("word", exp, word);
    @(posedge clk);
    #1 word_ready = 1'b0;
    // let an edge pass before the next call raises ready again
    @(posedge clk);
    #1;
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard
  initial begin
    #300000;
    errors++;
    close_out();
  end
  // test sequence
  initial begin
    rst = 1'b1;
    start_req = 1'b0;
    use_busy = 1'b1;
    word_ready = 1'b0;
    sample = 16'h0000;
    lk.byte_mode = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    check("idle bus", 16'hFFFF, lk.data_bus);
    // every width and completion method
    for (int m = 0; m < 4; m++) begin
      lk.byte_mode = m[1];
      use_busy = m[0];
      start(pat[m]);
      take(pat[m]);
      $display("test mode %0d done", m);
    end
    // receiver stalls across three conversions
    start(16'h0F0F);
    start(16'hF0F0);
    start(16'h3C3C);
    repeat (900) @(posedge clk);
    #1 take(16'h0F0F);
    take(16'hF0F0);
    take(16'h3C3C);
    check("drained", 16'h0000, {15'h0000, word_valid});
    check("bus released", 16'hFFFF, lk.data_bus);
    check("conversions", 16'h0007, n_done[15:0]);
    $display("test stall done");
    close_out();
  end
endmodule // adc_conversion_host_interface_bench
